//--- rtc_pkg.sv
// Shared constants for the single-wire seconds clock slave.
// Assumes one 250 MHz clock; every time below is in microseconds.
package rtc_pkg;

  // ==========================================================
  // Clock and bus timing
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned SAMPLE_US        = 30;
  localparam int unsigned READ0_US         = 30;
  localparam int unsigned PRES_WAIT_US     = 30;
  localparam int unsigned PRES_LOW_US      = 120;
  localparam int unsigned RESET_LOW_US     = 240;
  localparam int unsigned SECOND_US        = 1_000_000;
  localparam int unsigned SAMPLE_CYCLES    = SAMPLE_US * CLK_MHZ;
  localparam int unsigned READ0_CYCLES     = READ0_US * CLK_MHZ;
  localparam int unsigned PRES_WAIT_CYCLES = PRES_WAIT_US * CLK_MHZ;
  localparam int unsigned PRES_LOW_CYCLES  = PRES_LOW_US * CLK_MHZ;
  localparam int unsigned RESET_CYCLES     = RESET_LOW_US * CLK_MHZ;
  localparam int unsigned SECOND_CYCLES    = SECOND_US * CLK_MHZ;

  // ==========================================================
  // Buffering and layout
  localparam int unsigned FIFO_DEPTH   = 16;
  localparam int unsigned FIFO_WIDTH   = 1;
  localparam int unsigned ID_BITS      = 64;
  localparam int unsigned STREAM_BITS  = 40;
  localparam int unsigned CTRL_OSC_LO  = 2;
  localparam int unsigned CTRL_OSC_HI  = 3;
  localparam int unsigned CTRL_FLAG_LO = 4;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [31:0] COUNT_RESET  = 32'h0000_0000;
  localparam logic [7:0]  CRC_POLY_REV = 8'h8C;

  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_READ_ROM   = 8'h33;
  localparam logic [7:0] CMD_MATCH_ROM  = 8'h55;
  localparam logic [7:0] CMD_SKIP_ROM   = 8'hCC;
  localparam logic [7:0] CMD_SEARCH_ROM = 8'hF0;
  localparam logic [7:0] CMD_READ_CLK   = 8'h66;
  localparam logic [7:0] CMD_WRITE_CLK  = 8'h99;

  typedef enum logic [3:0] {
    ST_WAIT   = 4'h0,
    ST_ROMCMD = 4'h1,
    ST_RDROM  = 4'h2,
    ST_MATCH  = 4'h3,
    ST_SEARCH = 4'h4,
    ST_FUNC   = 4'h5,
    ST_RDCLK  = 4'h6,
    ST_WRCLK  = 4'h7
  } proto_state_t;

  typedef enum logic [2:0] {
    PH_IDLE   = 3'h0,
    PH_LOW    = 3'h1,
    PH_HOLD   = 3'h2,
    PH_PWAIT  = 3'h3,
    PH_PDRIVE = 3'h4
  } phy_state_t;

  // Reflected CRC over the first 56 identity bits, LSB first
  function automatic logic [7:0] crc8(input logic [55:0] data);
    logic [7:0] crc;
    crc = 8'h00;
    for (int i = 0; i < 56; i++) begin
      if (crc[0] ^ data[i]) begin
        crc = (crc >> 1) ^ CRC_POLY_REV;
      end else begin
        crc = crc >> 1;
      end
    end
    return crc;
  endfunction

endpackage

//--- slot_if.sv
// Carrier between the line timing engine and the protocol engine.
// Assumes both ends sit on clk_sys.
interface slot_if;
  logic busReset;
  logic bitValid;
  logic bitVal;
  logic txEn;
  logic txBit;
  modport phy   (output busReset, output bitValid, output bitVal, input txEn, input txBit);
  modport proto (input busReset, input bitValid, input bitVal, output txEn, output txBit);
endinterface

//--- bit_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides and a flush.
// Assumes a single clock domain.
module bit_fifo #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else if (flush) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

//--- line_phy.sv
// Bit slot, reset and presence timing on the open-drain line.
// Assumes dqIn is already synchronous to clk_sys.
module line_phy #(
  parameter int unsigned SAMPLE = rtc_pkg::SAMPLE_CYCLES,
  parameter int unsigned READ0  = rtc_pkg::READ0_CYCLES,
  parameter int unsigned PWAIT  = rtc_pkg::PRES_WAIT_CYCLES,
  parameter int unsigned PLOW   = rtc_pkg::PRES_LOW_CYCLES,
  parameter int unsigned RSTLOW = rtc_pkg::RESET_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic dqIn,
  output logic      dqOe,
  slot_if.phy       link
);
  rtc_pkg::phy_state_t state;
  logic [31:0]         cnt;
  logic                dqPrev;

  assign dqOe = (state == rtc_pkg::PH_HOLD) || (state == rtc_pkg::PH_PDRIVE);

  // ==========================================================
  // Slot engine
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state         <= rtc_pkg::PH_IDLE;
      cnt           <= 32'h0000_0000;
      dqPrev        <= 1'b1;
      link.busReset <= 1'b0;
      link.bitValid <= 1'b0;
      link.bitVal   <= 1'b1;
    end else begin
      dqPrev        <= dqIn;
      link.busReset <= 1'b0;
      link.bitValid <= 1'b0;
      unique case (state)
        rtc_pkg::PH_IDLE: begin
          if (dqPrev && !dqIn) begin
            cnt <= 32'h0000_0001;
            if (link.txEn && !link.txBit) begin
              state <= rtc_pkg::PH_HOLD;
            end else begin
              state <= rtc_pkg::PH_LOW;
            end
          end
        end
        rtc_pkg::PH_HOLD: begin
          cnt <= cnt + 32'h0000_0001;
          // Falls into LOW so a reset hidden behind our own pull is still seen
          if (cnt >= READ0) begin
            state <= rtc_pkg::PH_LOW;
          end
        end
        rtc_pkg::PH_LOW: begin
          if (dqIn) begin
            cnt <= 32'h0000_0000;
            if (cnt >= RSTLOW) begin
              link.busReset <= 1'b1;
              state         <= rtc_pkg::PH_PWAIT;
            end else begin
              link.bitValid <= 1'b1;
              link.bitVal   <= (cnt < SAMPLE);
              state         <= rtc_pkg::PH_IDLE;
            end
          end else if (cnt != 32'hFFFF_FFFF) begin
            cnt <= cnt + 32'h0000_0001;
          end
        end
        rtc_pkg::PH_PWAIT: begin
          cnt <= cnt + 32'h0000_0001;
          if (cnt >= PWAIT) begin
            cnt   <= 32'h0000_0000;
            state <= rtc_pkg::PH_PDRIVE;
          end
        end
        rtc_pkg::PH_PDRIVE: begin
          cnt <= cnt + 32'h0000_0001;
          if (cnt >= PLOW) begin
            cnt   <= 32'h0000_0000;
            state <= rtc_pkg::PH_IDLE;
          end
        end
        default: begin
          state <= rtc_pkg::PH_IDLE;
        end
      endcase
    end
  end
endmodule

//--- seconds_rtc.sv
// Single-wire seconds clock slave: identity handling, clock commands,
// live seconds counter, read/write buffer and control byte.
// Assumes dqIn is synchronous to clk_sys; the pin itself is resolved outside.
module seconds_rtc #(
  parameter logic [7:0]  FAMILY_CODE   = 8'h5A,             // Arbitrary value
  parameter logic [47:0] SERIAL_NUMBER = 48'h0000_1234_5678, // Arbitrary value
  parameter int unsigned SECOND_CYCLES = rtc_pkg::SECOND_CYCLES,
  parameter int unsigned SAMPLE        = rtc_pkg::SAMPLE_CYCLES,
  parameter int unsigned READ0         = rtc_pkg::READ0_CYCLES,
  parameter int unsigned PWAIT         = rtc_pkg::PRES_WAIT_CYCLES,
  parameter int unsigned PLOW          = rtc_pkg::PRES_LOW_CYCLES,
  parameter int unsigned RSTLOW        = rtc_pkg::RESET_CYCLES,
  parameter int unsigned FIFO_DEPTH    = rtc_pkg::FIFO_DEPTH
) (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic dqIn,
  output logic      dqOut,
  output logic      dqOe
);
  // ==========================================================
  // Identity
  localparam logic [55:0] ID_BODY = {SERIAL_NUMBER, FAMILY_CODE};
  localparam logic [63:0] ROM_ID  = {rtc_pkg::crc8(ID_BODY), ID_BODY};

  // ==========================================================
  // Declarations
  slot_if link ();

  rtc_pkg::proto_state_t state;
  logic [31:0]           liveCount;
  logic [31:0]           rwBuffer;
  logic [31:0]           tick;
  logic [7:0]            ctrl;
  logic [7:0]            shiftIn;
  logic [7:0]            next_byte;
  logic [5:0]            bitIdx;
  logic [1:0]            searchPhase;
  logic                  commitPending;
  logic                  settle;
  logic                  bitAvail;
  logic                  bitTake;
  logic                  bitData;
  logic                  fifoInReady;
  logic                  oscOn;
  logic [7:0]            ctrlRead;
  logic [39:0]           stream;
  logic                  idBit;
  logic                  bitStep;
  logic                  funcDone;
  logic                  wrByteEnd;

  assign dqOut     = 1'b0;
  assign oscOn     = ctrl[rtc_pkg::CTRL_OSC_HI];
  assign ctrlRead  = {ctrl[7:rtc_pkg::CTRL_FLAG_LO], oscOn, oscOn, 2'b00};
  assign stream    = {rwBuffer, ctrlRead};
  assign idBit     = ROM_ID[bitIdx];
  assign next_byte = {bitData, shiftIn[7:1]};

  // One idle cycle after each taken bit lets the answer bit settle
  assign bitTake = bitAvail && !settle;

  // ==========================================================
  // Line timing and sampled-bit queue
  line_phy #(
    .SAMPLE (SAMPLE),
    .READ0  (READ0),
    .PWAIT  (PWAIT),
    .PLOW   (PLOW),
    .RSTLOW (RSTLOW)
  ) u_phy (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .dqIn    (dqIn),
    .dqOe    (dqOe),
    .link    (link.phy)
  );

  // Full queue drops the slot; at one slot per 60 us it cannot fill in practice
  bit_fifo #(
    .WIDTH (rtc_pkg::FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .flush    (link.busReset),
    .inValid  (link.bitValid),
    .inReady  (fifoInReady),
    .inData   (link.bitVal),
    .outValid (bitAvail),
    .outReady (!settle),
    .outData  (bitData)
  );

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      settle <= 1'b0;
    end else begin
      settle <= bitTake;
    end
  end

  // ==========================================================
  // Answer bit for the next read slot
  always_comb begin
    link.txEn  = 1'b0;
    link.txBit = 1'b1;
    unique case (state)
      rtc_pkg::ST_RDROM: begin
        link.txEn  = 1'b1;
        link.txBit = idBit;
      end
      rtc_pkg::ST_SEARCH: begin
        link.txEn  = (searchPhase != 2'd2);
        link.txBit = (searchPhase == 2'd0) ? idBit : !idBit;
      end
      rtc_pkg::ST_RDCLK: begin
        link.txEn  = 1'b1;
        link.txBit = stream[bitIdx];
      end
      default: begin
        link.txEn  = 1'b0;
        link.txBit = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // Seconds prescaler and live counter
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tick <= 32'h0000_0000;
    end else if (!oscOn) begin
      tick <= 32'h0000_0000;
    end else if (tick >= SECOND_CYCLES - 1) begin
      tick <= 32'h0000_0000;
    end else begin
      tick <= tick + 32'h0000_0001;
    end
  end

  // Only rstn clears time; a bus reset merely commits a pending write
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      liveCount <= rtc_pkg::COUNT_RESET;
    end else if (link.busReset && commitPending) begin
      liveCount <= rwBuffer;
    end else if (oscOn && tick >= SECOND_CYCLES - 1) begin
      liveCount <= liveCount + 32'h0000_0001;
    end
  end

  // ==========================================================
  // Protocol engine
  // A bus reset outranks a bit taken in the same cycle
  assign bitStep   = bitTake && !link.busReset;
  assign funcDone  = bitStep && (state == rtc_pkg::ST_FUNC) && (bitIdx == 6'd7);
  assign wrByteEnd = bitStep && (state == rtc_pkg::ST_WRCLK) && (bitIdx[2:0] == 3'd7);

  // Bits arrive low first, so each one enters at the top
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      shiftIn <= 8'h00;
    end else if (link.busReset) begin
      shiftIn <= 8'h00;
    end else if (bitTake) begin
      shiftIn <= next_byte;
    end
  end

  // Three slots per identity bit: bit, complement, master's choice
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      searchPhase <= 2'd0;
    end else if (link.busReset) begin
      searchPhase <= 2'd0;
    end else if (bitStep && (state == rtc_pkg::ST_SEARCH)) begin
      searchPhase <= (searchPhase == 2'd2) ? 2'd0 : searchPhase + 2'd1;
    end
  end

  // Only rstn clears the control byte; a bus reset never does
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl <= rtc_pkg::CTRL_RESET;
    end else if (wrByteEnd && (bitIdx[5:3] == 3'd0)) begin
      ctrl <= next_byte;
    end
  end

  // Write preloads too, so a short write leaves unwritten bytes unchanged
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rwBuffer <= rtc_pkg::COUNT_RESET;
    end else if (funcDone &&
                 (next_byte == rtc_pkg::CMD_READ_CLK || next_byte == rtc_pkg::CMD_WRITE_CLK)) begin
      rwBuffer <= liveCount;
    end else if (wrByteEnd) begin
      unique case (bitIdx[5:3])
        3'd1: rwBuffer[7:0]   <= next_byte;
        3'd2: rwBuffer[15:8]  <= next_byte;
        3'd3: rwBuffer[23:16] <= next_byte;
        3'd4: rwBuffer[31:24] <= next_byte;
        default: ;
      endcase
    end
  end

  // A control-only write leaves time alone at the next bus reset
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      commitPending <= 1'b0;
    end else if (link.busReset) begin
      commitPending <= 1'b0;
    end else if (wrByteEnd && (bitIdx[5:3] != 3'd0)) begin
      commitPending <= 1'b1;
    end
  end

  // Unknown codes and identity misses park in WAIT until the next bus reset
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state  <= rtc_pkg::ST_WAIT;
      bitIdx <= 6'd0;
    end else if (link.busReset) begin
      state  <= rtc_pkg::ST_ROMCMD;
      bitIdx <= 6'd0;
    end else if (bitTake) begin
      unique case (state)
        rtc_pkg::ST_WAIT: begin
          bitIdx <= 6'd0;
        end
        rtc_pkg::ST_ROMCMD: begin
          bitIdx <= bitIdx + 6'd1;
          if (bitIdx == 6'd7) begin
            bitIdx <= 6'd0;
            if (next_byte == rtc_pkg::CMD_READ_ROM) begin
              state <= rtc_pkg::ST_RDROM;
            end else if (next_byte == rtc_pkg::CMD_MATCH_ROM) begin
              state <= rtc_pkg::ST_MATCH;
            end else if (next_byte == rtc_pkg::CMD_SKIP_ROM) begin
              state <= rtc_pkg::ST_FUNC;
            end else if (next_byte == rtc_pkg::CMD_SEARCH_ROM) begin
              state <= rtc_pkg::ST_SEARCH;
            end else begin
              state <= rtc_pkg::ST_WAIT;
            end
          end
        end
        rtc_pkg::ST_RDROM: begin
          bitIdx <= bitIdx + 6'd1;
          if (bitIdx == 6'd63) begin
            state <= rtc_pkg::ST_FUNC;
          end
        end
        rtc_pkg::ST_MATCH: begin
          bitIdx <= bitIdx + 6'd1;
          if (bitData != idBit) begin
            state <= rtc_pkg::ST_WAIT;
          end else if (bitIdx == 6'd63) begin
            state <= rtc_pkg::ST_FUNC;
          end
        end
        // Identity bit advances only after the master's choice
        rtc_pkg::ST_SEARCH: begin
          if (searchPhase == 2'd2) begin
            bitIdx <= bitIdx + 6'd1;
            if (bitData != idBit) begin
              state <= rtc_pkg::ST_WAIT;
            end else if (bitIdx == 6'd63) begin
              state <= rtc_pkg::ST_FUNC;
            end
          end
        end
        rtc_pkg::ST_FUNC: begin
          bitIdx <= bitIdx + 6'd1;
          if (bitIdx == 6'd7) begin
            bitIdx <= 6'd0;
            if (next_byte == rtc_pkg::CMD_READ_CLK) begin
              state <= rtc_pkg::ST_RDCLK;
            end else if (next_byte == rtc_pkg::CMD_WRITE_CLK) begin
              state <= rtc_pkg::ST_WRCLK;
            end else begin
              state <= rtc_pkg::ST_WAIT;
            end
          end
        end
        // Read stream wraps after the fifth byte, from the same snapshot
        rtc_pkg::ST_RDCLK: begin
          if (bitIdx == 6'(rtc_pkg::STREAM_BITS - 1)) begin
            bitIdx <= 6'd0;
          end else begin
            bitIdx <= bitIdx + 6'd1;
          end
        end
        // Bytes after the fifth fall on WAIT and are ignored
        rtc_pkg::ST_WRCLK: begin
          bitIdx <= bitIdx + 6'd1;
          if (bitIdx == 6'(rtc_pkg::STREAM_BITS - 1)) begin
            state <= rtc_pkg::ST_WAIT;
          end
        end
        default: begin
          state <= rtc_pkg::ST_WAIT;
        end
      endcase
    end
  end

  // fifoInReady only matters if the queue is ever undersized
  logic unusedReady;
  assign unusedReady = fifoInReady;

endmodule

//--- seconds_rtc_props.sv
// Checker for the line pins of the seconds clock slave.
// Assumes it is bound onto seconds_rtc and inherits its timing parameters.
module seconds_rtc_props #(
  parameter int unsigned READ0  = 40,
  parameter int unsigned PWAIT  = 20,
  parameter int unsigned PLOW   = 50,
  parameter int unsigned RSTLOW = 200
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic dqIn,
  input wire logic dqOut,
  input wire logic dqOe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] lowCnt;
  logic [15:0] oeLen;
  logic [15:0] sinceRst;
  logic        inPres;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // Line history
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) lowCnt <= 16'h0000;
    else if (dqIn) lowCnt <= 16'h0000;
    else if (lowCnt != 16'hFFFF) lowCnt <= lowCnt + 16'h0001;
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) oeLen <= 16'h0000;
    else if (!dqOe) oeLen <= 16'h0000;
    else oeLen <= oeLen + 16'h0001;
  end
  // Margin of two cycles keeps the detector clear of the design threshold
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sinceRst <= 16'h0000;
      inPres   <= 1'b0;
    end else if (dqIn && lowCnt > RSTLOW + 2) begin
      sinceRst <= 16'h0000;
      inPres   <= 1'b1;
    end else begin
      if (sinceRst != 16'hFFFF) sinceRst <= sinceRst + 16'h0001;
      if ($fell(dqOe)) inPres <= 1'b0;
    end
  end
  // ==========================================================
  // Properties
  property p_out_zero; dqOut == 1'b0; endproperty
  a_out_zero: assert property (p_out_zero) else $error("dqOut not zero");
  property p_pres_early; inPres && sinceRst < PWAIT - 1 |-> !dqOe; endproperty
  a_pres_early: assert property (p_pres_early) else $error("presence too early");
  property p_pres_due; inPres && sinceRst == PWAIT + 4 |-> dqOe; endproperty
  a_pres_due: assert property (p_pres_due) else $error("presence missing");
  property p_pres_len; $fell(dqOe) && inPres |-> oeLen == PLOW + 1; endproperty
  a_pres_len: assert property (p_pres_len) else $error("presence length wrong");
  property p_read0_start; $rose(dqOe) && !inPres |-> !$past(dqIn) && $past(dqIn, 2); endproperty
  a_read0_start: assert property (p_read0_start) else $error("drive not after falling edge");
  property p_read0_len; $fell(dqOe) && !inPres |-> oeLen == READ0; endproperty
  a_read0_len: assert property (p_read0_len) else $error("read zero hold wrong");
  property p_oe_hold; dqOe && oeLen < READ0 - 1 |=> dqOe; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("drive dropped early");
  property p_long_low; lowCnt > PLOW + READ0 |-> !dqOe; endproperty
  a_long_low: assert property (p_long_low) else $error("drive during long low");
  c_presence: cover property (inPres && $rose(dqOe));
  c_read0: cover property (!inPres && $rose(dqOe));
  c_reset: cover property (dqIn && lowCnt > RSTLOW + 2);
endmodule

bind seconds_rtc seconds_rtc_props #(.READ0(READ0), .PWAIT(PWAIT), .PLOW(PLOW), .RSTLOW(RSTLOW))
  seconds_rtc_props_inst (.clk_sys(clk_sys), .rstn(rstn), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe));

//--- bus_master.sv
// Behavioural single-wire bus master with pull-up line resolution.
// Assumes shortened slave timing: sample 30, read-0 hold 40, reset 200.
module bus_master (
  input  wire logic clk_sys,
  input  wire logic dqOe,
  output logic      dqLine
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mHigh = 1'b1;
  // Pull-up: line rests high unless a party pulls it low
  assign dqLine = mHigh & ~dqOe;
  // ==========================================================
  // Slot primitives, all starting with a falling edge
  task automatic lowFor(input int n, input int slot);
    mHigh = 1'b0;
    repeat (n) @(negedge clk_sys);
    mHigh = 1'b1;
    repeat (slot - n) @(negedge clk_sys);
  endtask
  task automatic busReset(input int n, output logic pres);
    lowFor(n, n);
    pres = 1'b0;
    repeat (160) begin
      @(negedge clk_sys);
      if (!dqLine) pres = 1'b1;
    end
  endtask
  task automatic writeBit(input logic b);
    lowFor(b ? 3 : 60, 80);
  endtask
  task automatic readBit(output logic b);
    lowFor(3, 15);
    b = dqLine;
    repeat (65) @(negedge clk_sys);
  endtask
  task automatic writeBits(input logic [63:0] v, input int n);
    for (int i = 0; i < n; i++) writeBit(v[i]);
  endtask
  task automatic readBits(input int n, output logic [63:0] v);
    logic b;
    v = 64'h0;
    for (int i = 0; i < n; i++) begin
      readBit(b);
      v[i] = b;
    end
  endtask
endmodule

//--- single_wire_binary_rtc_tb.sv
// Self-checking bench for the seconds clock slave on one open-drain line.
// Assumes bus_master as the far side and shortened timing parameters.
module single_wire_binary_rtc_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0]  FAMILY = 8'h5A;              // Arbitrary value
  localparam logic [47:0] SERIAL = 48'h0000_1234_5678; // Arbitrary value
  localparam int unsigned SEC_CYC    = 2000;
  localparam int unsigned SAMPLE_CYC = 30;
  localparam int unsigned READ0_CYC  = 40;
  localparam int unsigned PWAIT_CYC  = 20;
  localparam int unsigned PLOW_CYC   = 50;
  localparam int unsigned RST_CYC    = 200;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        dqLine;
  logic        dqOut;
  logic        dqOe;
  logic [63:0] idCode;
  logic [63:0] v;
  logic [63:0] w;
  logic [63:0] sb;
  logic [63:0] sc;
  logic        b;
  logic        c;
  logic        p;
  int          bad_count = 0;
  int          n_tests = 0;
  int          cycles = 0;
  always #2 clk_sys = ~clk_sys;
  seconds_rtc #(.FAMILY_CODE(FAMILY), .SERIAL_NUMBER(SERIAL), .SECOND_CYCLES(SEC_CYC), .SAMPLE(SAMPLE_CYC),
    .READ0(READ0_CYC), .PWAIT(PWAIT_CYC), .PLOW(PLOW_CYC), .RSTLOW(RST_CYC)) seconds_rtc_inst (.clk_sys(clk_sys),
    .rstn(rstn), .dqIn(dqLine), .dqOut(dqOut), .dqOe(dqOe));
  bus_master bus_master_inst (.clk_sys(clk_sys), .dqOe(dqOe), .dqLine(dqLine));
  // ==========================================================
  // Helpers
  function automatic logic [7:0] crcOf(input logic [55:0] d);
    logic [7:0] k;
    k = 8'h00;
    for (int i = 0; i < 56; i++) k = (k[0] ^ d[i]) ? ((k >> 1) ^ 8'h8C) : (k >> 1);
    return k;
  endfunction
  task automatic check_val(input string what, input logic [63:0] expv, input logic [63:0] gotv);
    n_tests++;
    if (gotv !== expv) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, expv, gotv);
    end
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic sendByte(input logic [7:0] x);
    bus_master_inst.writeBits({56'h0, x}, 8);
  endtask
  task automatic start(input logic [7:0] rom);
    logic pr;
    bus_master_inst.busReset(300, pr);
    check_val("presence", 64'h1, {63'h0, pr});
    sendByte(rom);
  endtask
  // Ceiling above the expected run of about 77000 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 99000) begin
      bad_count++;
      give_verdict();
    end
  end
  // ==========================================================
  // Sequence
  initial begin
    idCode = {crcOf({SERIAL, FAMILY}), SERIAL, FAMILY};
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1'b1;
    repeat (4) @(negedge clk_sys);
    start(rtc_pkg::CMD_READ_ROM);
    bus_master_inst.readBits(64, v);
    check_val("identity", idCode, v);
    // Bit 2 set but bit 3 clear: oscillator must stay off
    start(rtc_pkg::CMD_SKIP_ROM);
    sendByte(rtc_pkg::CMD_WRITE_CLK);
    bus_master_inst.writeBits({24'h0, 32'hFFFF_FFFF, 8'h57}, 40);
    bus_master_inst.busReset(3000, p);
    start(rtc_pkg::CMD_SKIP_ROM);
    sendByte(rtc_pkg::CMD_READ_CLK);
    bus_master_inst.readBits(40, v);
    check_val("stopped clock", {24'h0, 32'hFFFF_FFFF, 8'h50}, v);
    bus_master_inst.readBits(40, w);
    check_val("second pass", v, w);
    bus_master_inst.readBits(12, w);
    start(rtc_pkg::CMD_SKIP_ROM);
    sendByte(rtc_pkg::CMD_READ_CLK);
    bus_master_inst.readBits(8, v);
    check_val("after abort", 64'h50, v);
    // Oscillator on through bit 3 alone, counter set to wrap
    start(rtc_pkg::CMD_SKIP_ROM);
    sendByte(rtc_pkg::CMD_WRITE_CLK);
    bus_master_inst.writeBits({24'h0, 32'hFFFF_FFFF, 8'h08}, 40);
    start(rtc_pkg::CMD_SKIP_ROM);
    repeat (2100) @(negedge clk_sys);
    sendByte(rtc_pkg::CMD_READ_CLK);
    bus_master_inst.readBits(40, v);
    check_val("running control", 64'h0C, {56'h0, v[7:0]});
    check_val("wrapped", 64'h1, {63'h0, v[39:8] <= 32'h1});
    bus_master_inst.readBits(40, w);
    check_val("frozen snapshot", v, w);
    bus_master_inst.busReset(300, p);
    sendByte(rtc_pkg::CMD_READ_CLK);
    bus_master_inst.readBits(8, v);
    check_val("no identity step", 64'hFF, v);
    start(rtc_pkg::CMD_MATCH_ROM);
    bus_master_inst.writeBits(idCode ^ 64'h0000_0100_0000_0000, 64);
    sendByte(rtc_pkg::CMD_READ_CLK);
    bus_master_inst.readBits(8, v);
    check_val("match miss", 64'hFF, v);
    start(rtc_pkg::CMD_MATCH_ROM);
    bus_master_inst.writeBits(idCode, 64);
    sendByte(rtc_pkg::CMD_READ_CLK);
    bus_master_inst.readBits(8, v);
    check_val("match hit", 64'h0C, v);
    start(rtc_pkg::CMD_SEARCH_ROM);
    for (int i = 0; i < 64; i++) begin
      bus_master_inst.readBit(b);
      bus_master_inst.readBit(c);
      sb[i] = b;
      sc[i] = c;
      bus_master_inst.writeBit(idCode[i]);
    end
    check_val("search bits", idCode, sb);
    check_val("search complements", ~idCode, sc);
    sendByte(rtc_pkg::CMD_READ_CLK);
    bus_master_inst.readBits(8, v);
    check_val("after search", 64'h0C, v);
    start(rtc_pkg::CMD_SEARCH_ROM);
    bus_master_inst.readBits(2, v);
    bus_master_inst.writeBit(~idCode[0]);
    bus_master_inst.readBits(2, v);
    check_val("search dropout", 64'h3, v);
    give_verdict();
  end
endmodule
